// ===== design/sclk_regs.vh
`ifndef SCLK_REGS_VH
`define SCLK_REGS_VH
// ==================================================
// register byte addresses
`define SCLK_ADDR_CLK_CTRL 8'hD4
`define SCLK_ADDR_BT_CTRL 8'hDC
`define SCLK_ADDR_BT_COUNT 8'hE0
`define SCLK_ADDR_STATUS 8'hE4
// ==================================================
// system clock control fields
`define SCLK_CLK_WAKE_DIS 7
`define SCLK_CLK_SEL_HI 4
`define SCLK_CLK_SEL_LO 3
`define SCLK_CLK_MASK 8'h98
`define SCLK_CLK_RESET 8'h00
`define SCLK_SEL_DIV16 2'h0
`define SCLK_SEL_DIV8 2'h1
`define SCLK_SEL_DIV2 2'h2
`define SCLK_SEL_DIV1 2'h3
// ==================================================
// basic timer control fields
`define SCLK_BT_CNT_CLR 1
`define SCLK_BT_PRE_CLR 0
`define SCLK_BT_SEL_HI 3
`define SCLK_BT_SEL_LO 2
`define SCLK_BT_MASK 8'hFC
`define SCLK_BT_RESET 8'h00
`define SCLK_BT_SEL_4096 2'h0
`define SCLK_BT_SEL_1024 2'h1
`define SCLK_BT_SEL_128 2'h2
`define SCLK_BT_SEL_16 2'h3
// ==================================================
// status fields
`define SCLK_STAT_IRQ 0
`define SCLK_STAT_WAKE 1
// ==================================================
// prescaler taps (bit index of a 12-bit divider)
`define SCLK_PRE_W 12
`define SCLK_TAP_4096 11
`define SCLK_TAP_1024 9
`define SCLK_TAP_128 6
`define SCLK_TAP_16 3
`define SCLK_TAP_8 2
`define SCLK_TAP_2 0
`endif

// ===== design/sclk_prescaler.v
`include "sclk_regs.vh"
// ==================================================
// free-running divider; every bit toggles at half the rate of the one below
module sclk_prescaler (
  input wire i_clock,
  input wire i_rst,
  input wire i_clear,
  output reg [`SCLK_PRE_W-1:0] o_count,
  output wire [`SCLK_PRE_W-1:0] o_tick
);
  wire [`SCLK_PRE_W-1:0] next_count;
  assign next_count = o_count + {{(`SCLK_PRE_W-1){1'b0}}, 1'b1};
  // a tick is one cycle where bit k rises, i.e. rate fosc / 2^(k+1)
  genvar k;
  generate
    for (k = 0; k < `SCLK_PRE_W; k = k + 1) begin : g_tick
      assign o_tick[k] = ~o_count[k] & next_count[k] & ~i_clear;
    end
  endgenerate
  always @(posedge i_clock) begin
    if (i_rst || i_clear) begin // RULE3
      o_count <= {`SCLK_PRE_W{1'b0}};
    end else begin
      o_count <= next_count;
    end
  end
endmodule

// ===== design/sclk_clock_control.v
`include "sclk_regs.vh"
// How it works
// RULE1 - Writing one to the counter-clear bit of the timer control register zeroes the timer count.
// RULE2 - The counter-clear bit never stores a one, so it always reads back zero.
// RULE3 - Writing one to the divider-clear bit zeroes the shared prescaler; writing zero does nothing.
// RULE4 - The divider-clear bit never stores a one, so it always reads back zero.
// RULE5 - Clock control bit 7 low lets an oscillator wake-up raise a request in power-down; high blocks it.
// RULE6 - Clock control bits 4:3 pick the cpu rate: 00 /16, 01 /8, 10 /2, 11 undivided.
// RULE7 - Clock control resets to zero (divide by 16, wake-up request enabled) and unused bits read zero.
module sclk_clock_control (
  input wire i_clock,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  input wire i_power_down,
  input wire i_osc_wakeup,
  output wire o_cpu_clock_en,
  output wire [`SCLK_PRE_W-1:0] o_prescaler_tick,
  output wire o_timer_tick,
  output reg [7:0] o_timer_count,
  output reg o_wakeup_irq
);
  // ==================================================
  // register bus
  reg [7:0] clk_ctrl;
  reg [7:0] bt_ctrl;
  reg wake_s1;
  reg wake_s2;
  reg wake_prev;
  wire wr_access;
  wire rd_access;
  wire cnt_clear;
  wire pre_clear;
  wire [`SCLK_PRE_W-1:0] pre_count;
  wire [`SCLK_PRE_W-1:0] pre_tick;
  wire [1:0] cpu_sel;
  wire [1:0] bt_sel;
  wire wake_edge;
  reg next_cpu_en;
  reg next_bt_tick;
  reg [31:0] next_prdata;

  // decode of an 8-bit register address, used for reads, writes and errors
  function hit;
    input [31:0] addr;
    input [7:0] target;
    begin
      hit = (addr[31:8] == 24'h000000) && (addr[7:0] == target);
    end
  endfunction

  function mapped;
    input [31:0] addr;
    begin
      mapped = hit(addr, `SCLK_ADDR_CLK_CTRL) || hit(addr, `SCLK_ADDR_BT_CTRL) ||
        hit(addr, `SCLK_ADDR_BT_COUNT) || hit(addr, `SCLK_ADDR_STATUS);
    end
  endfunction

  // zero wait state slave; unmapped addresses answer with an error
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped(i_paddr);
  assign wr_access = i_psel & i_penable & i_pwrite;
  assign rd_access = i_psel & ~i_penable & ~i_pwrite;

  // command bits act for the access cycle only and are never stored
  assign cnt_clear = wr_access && hit(i_paddr, `SCLK_ADDR_BT_CTRL) &&
    i_pwdata[`SCLK_BT_CNT_CLR]; // RULE1
  assign pre_clear = wr_access && hit(i_paddr, `SCLK_ADDR_BT_CTRL) &&
    i_pwdata[`SCLK_BT_PRE_CLR]; // RULE3

  always @(posedge i_clock) begin
    if (i_rst) begin
      clk_ctrl <= `SCLK_CLK_RESET; // RULE7
      bt_ctrl <= `SCLK_BT_RESET;
    end else if (wr_access) begin
      if (hit(i_paddr, `SCLK_ADDR_CLK_CTRL)) begin
        clk_ctrl <= i_pwdata[7:0] & `SCLK_CLK_MASK; // RULE7
      end
      if (hit(i_paddr, `SCLK_ADDR_BT_CTRL)) begin
        bt_ctrl <= i_pwdata[7:0] & `SCLK_BT_MASK; // RULE2 RULE4
      end
    end
  end

  // read data registered in the setup cycle so it is stable in the access phase
  always @* begin
    next_prdata = 32'h00000000;
    if (hit(i_paddr, `SCLK_ADDR_CLK_CTRL)) begin
      next_prdata[7:0] = clk_ctrl;
    end else if (hit(i_paddr, `SCLK_ADDR_BT_CTRL)) begin
      next_prdata[7:0] = bt_ctrl; // RULE2 RULE4
    end else if (hit(i_paddr, `SCLK_ADDR_BT_COUNT)) begin
      next_prdata[7:0] = o_timer_count;
    end else if (hit(i_paddr, `SCLK_ADDR_STATUS)) begin
      next_prdata[`SCLK_STAT_IRQ] = o_wakeup_irq;
      next_prdata[`SCLK_STAT_WAKE] = wake_s2;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
    end else if (rd_access) begin
      o_prdata <= next_prdata;
    end
  end

  // ==================================================
  // shared prescaler
  sclk_prescaler u_pre (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clear(pre_clear),
    .o_count(pre_count),
    .o_tick(pre_tick)
  );
  assign o_prescaler_tick = pre_tick;

  // ==================================================
  // cpu clock enable
  assign cpu_sel = clk_ctrl[`SCLK_CLK_SEL_HI:`SCLK_CLK_SEL_LO];
  always @* begin
    case (cpu_sel) // RULE6
      `SCLK_SEL_DIV16: next_cpu_en = pre_tick[`SCLK_TAP_16];
      `SCLK_SEL_DIV8: next_cpu_en = pre_tick[`SCLK_TAP_8];
      `SCLK_SEL_DIV2: next_cpu_en = pre_tick[`SCLK_TAP_2];
      `SCLK_SEL_DIV1: next_cpu_en = 1'b1;
      default: next_cpu_en = 1'b1;
    endcase
  end
  // divided rates pause for a cycle on a prescaler clear: a short pulse is worse
  assign o_cpu_clock_en = next_cpu_en;

  // ==================================================
  // basic timer counter
  assign bt_sel = bt_ctrl[`SCLK_BT_SEL_HI:`SCLK_BT_SEL_LO];
  always @* begin
    case (bt_sel)
      `SCLK_BT_SEL_4096: next_bt_tick = pre_tick[`SCLK_TAP_4096];
      `SCLK_BT_SEL_1024: next_bt_tick = pre_tick[`SCLK_TAP_1024];
      `SCLK_BT_SEL_128: next_bt_tick = pre_tick[`SCLK_TAP_128];
      `SCLK_BT_SEL_16: next_bt_tick = pre_tick[`SCLK_TAP_16];
      default: next_bt_tick = 1'b0;
    endcase
  end
  assign o_timer_tick = next_bt_tick;

  always @(posedge i_clock) begin
    if (i_rst || cnt_clear) begin // RULE1
      o_timer_count <= 8'h00;
    end else if (next_bt_tick) begin
      o_timer_count <= o_timer_count + 8'h01;
    end
  end

  // ==================================================
  // oscillator wake-up request
  always @(posedge i_clock) begin
    if (i_rst) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_prev <= 1'b0;
    end else begin
      wake_s1 <= i_osc_wakeup;
      wake_s2 <= wake_s1;
      wake_prev <= wake_s2;
    end
  end
  assign wake_edge = wake_s2 & ~wake_prev;

  // one-cycle request; the interrupt controller keeps the pending state
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_wakeup_irq <= 1'b0;
    end else begin
      o_wakeup_irq <= wake_edge & i_power_down & ~clk_ctrl[`SCLK_CLK_WAKE_DIS]; // RULE5
    end
  end
endmodule

// ===== verif/sclk_checker.sv
module sclk_checker (
  input wire i_clock,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire i_power_down,
  input wire [11:0] o_prescaler_tick,
  input wire [7:0] o_timer_count,
  input wire o_wakeup_irq
);
  // ==========
  // access decode
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire acc = i_psel && i_penable;
  wire wr_bt = acc && i_pwrite && i_paddr == 32'hDC;
  wire rd_bt = acc && !i_pwrite && i_paddr == 32'hDC;
  wire rd_ck = acc && !i_pwrite && i_paddr == 32'hD4;
  count_clear_a: assert property (wr_bt && i_pwdata[1] |=> o_timer_count == 8'h00)
    else $error("timer count not cleared");
  cnt_bit_zero_a: assert property (rd_bt |-> !o_prdata[1])
    else $error("count clear bit reads one");
  div_clear_a: assert property (wr_bt && i_pwdata[0] |-> o_prescaler_tick == 12'h000)
    else $error("prescaler ticked while cleared");
  div_bit_zero_a: assert property (rd_bt |-> !o_prdata[0])
    else $error("divider clear bit reads one");
  wake_gate_a: assert property (o_wakeup_irq |-> $past(i_power_down))
    else $error("wake request outside power down");
  unused_zero_a: assert property (rd_ck |-> (o_prdata & 32'hFFFFFF67) == 32'h0)
    else $error("unused clock bits read one");
  reset_value_a: assert property ($fell(i_rst) |-> o_timer_count == 8'h00 && !o_wakeup_irq)
    else $error("bad state after reset");
  cover property (wr_bt && i_pwdata[1]);
  cover property (wr_bt && i_pwdata[0]);
  cover property (o_wakeup_irq);
endmodule
bind sclk_clock_control sclk_checker u_chk (.i_clock, .i_rst, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_prdata, .i_power_down, .o_prescaler_tick, .o_timer_count,
  .o_wakeup_irq);

// ===== verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 1'b0, i_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_power_down = 1'b0, i_osc_wakeup = 1'b0, perr;
  logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0, q;
  wire o_pready, o_pslverr, o_cpu_clock_en, o_timer_tick, o_wakeup_irq;
  wire [31:0] o_prdata;
  wire [11:0] o_prescaler_tick;
  wire [7:0] o_timer_count;
  int n_mismatch = 0, checks_done = 0, c;
  int e6[4] = '{2, 4, 16, 32};
  int e5[3] = '{1, 0, 0};
  logic [31:0] w5[3] = '{32'h00, 32'h80, 32'h00};
  always #5 i_clock = ~i_clock;
  sclk_clock_control DUT (.i_clock, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .i_power_down, .i_osc_wakeup,
    .o_cpu_clock_en, .o_prescaler_tick, .o_timer_tick, .o_timer_count, .o_wakeup_irq);
  // ==========
  // bus and check tasks
  task end_sim;
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] d);
    int n;
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      n_mismatch++;
      end_sim;
    end
    q = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task rd(input [31:0] a, input [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(q, e);
  endtask
  // pulses are counted at the falling edge, where combinational outputs have settled
  task count(input int s, input int n);
    c = 0;
    repeat (n) begin
      @(negedge i_clock);
      c += (s == 0) ? (o_cpu_clock_en === 1'b1) :
           (s == 1) ? (o_prescaler_tick[3] === 1'b1) :
           (s == 3) ? (o_timer_tick === 1'b1) : (o_wakeup_irq === 1'b1);
    end
  endtask
  // clearing right after a tick moves the next tick from 14 to 8 cycles away
  task pre_clear(input [31:0] d, input int e);
    int n;
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_prescaler_tick[3] !== 1'b1 && n < 40);
    if (o_prescaler_tick[3] !== 1'b1) begin
      n_mismatch++;
      end_sim;
    end
    xfer(1'b1, 32'hDC, d);
    count(1, 10);
    cmp(c, e);
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(32'hD4, 32'h00);
    cmp(perr, 1'b0);
    rd(32'hDC, 32'h00);
    rd(32'h40, 32'h00);
    cmp(perr, 1'b1);
    xfer(1'b1, 32'hD4, 32'hFF);
    rd(32'hD4, 32'h98);
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, 32'hD4, s << 3);
      count(0, 32);
      cmp(c, e6[s]);
    end
    pre_clear(32'h01, 1);
    pre_clear(32'h00, 0);
    xfer(1'b1, 32'hDC, 32'h0C);
    count(3, 32);
    cmp(c, 2);
    cmp(|o_timer_count, 1'b1);
    xfer(1'b1, 32'hDC, 32'h0E);
    @(negedge i_clock);
    cmp(o_timer_count, 8'h00);
    rd(32'hDC, 32'h0C);
    for (int k = 0; k < 3; k++) begin
      i_power_down <= (k < 2);
      xfer(1'b1, 32'hD4, w5[k]);
      i_osc_wakeup <= 1'b1;
      count(2, 8);
      cmp(c, e5[k]);
      rd(32'hE4, 32'h02);
      @(posedge i_clock);
      i_osc_wakeup <= 1'b0;
      repeat (4) @(posedge i_clock);
    end
    // a second reset in mid-run must bring the control register back to zero
    xfer(1'b1, 32'hD4, 32'h98);
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    rd(32'hD4, 32'h00);
    cmp(o_timer_count, 8'h00);
    end_sim;
  end
endmodule
